// ===== hdl/rcl_regs.vh
// Constants for the regulator control logic: states, strap codes, bus address, timing
`ifndef RCL_REGS_VH
`define RCL_REGS_VH
// Sequencer states, one-hot
`define RCL_ST_W        10
`define RCL_ST_NOPWR    10'h001
`define RCL_ST_BRAMP    10'h002
`define RCL_ST_RCHK     10'h004
`define RCL_ST_BRDY     10'h008
`define RCL_ST_MRAMP    10'h010
`define RCL_ST_MON      10'h020
`define RCL_ST_SERVO    10'h040
`define RCL_ST_BRST     10'h080
`define RCL_ST_MSHUT    10'h100
`define RCL_ST_MERR     10'h200
// Strap codes for the bus id resistor (0 ground short .. 5 open)
`define RCL_STRAP_GND   3'h0
`define RCL_STRAP_20K   3'h1
`define RCL_STRAP_30K   3'h2
`define RCL_STRAP_40K   3'h3
`define RCL_STRAP_50K   3'h4
`define RCL_STRAP_OPEN  3'h5
// Base 7-bit target address for the ground short strap
`define RCL_ADDR_BASE   7'h08
// Clock roles
`define RCL_ROLE_ALONE  2'h0
`define RCL_ROLE_SLAVE  2'h1
`define RCL_ROLE_MASTER 2'h2
// Register pointer targets of the voltage and current setpoints
`define RCL_REG_VSET    8'h00
`define RCL_REG_ISET    8'h01
// Timing: clock in MHz, reset delay and hiccup time
`define RCL_CLK_MHZ     100
`define RCL_TRESET_US   1000
`define RCL_HICCUP_MS   100
`define RCL_RESET_CYC   (`RCL_TRESET_US * `RCL_CLK_MHZ)
`define RCL_HICCUP_CYC  (`RCL_HICCUP_MS * 1000 * `RCL_CLK_MHZ)
// Bit counts of the serial bus
`define RCL_BIT_LAST    4'h7
`define RCL_BIT_ACK     4'h8
`define RCL_BIT_FIFTH   4'h4
`define RCL_BIT_PRE     4'hF
`endif

// ===== hdl/rcl_i2c_target.v
// Serial bus target: address match, register pointer, byte writes and reads
`timescale 1ns/100ps
`include "rcl_regs.vh"
module rcl_i2c_target #(
   parameter NREG = 16
) (
   // Clock and reset
   input  wire         clk_sys,
   input  wire         rst,
   input  wire         clk_en,
   // Bus pins (oe low = drive low)
   input  wire         scl_in,
   input  wire         sda_in,
   output reg          sda_oe_n_q,
   // Strap-selected address
   input  wire [6:0]   dev_addr,
   // Register file side
   output reg          wr_stb_q,
   output reg  [7:0]   wr_addr_q,
   output reg  [7:0]   wr_data_q,
   output wire [7:0]   rd_addr,
   input  wire [7:0]   rd_data
);
   localparam S_IDLE = 4'h1;
   localparam S_ADDR = 4'h2;
   localparam S_WR   = 4'h4;
   localparam S_RD   = 4'h8;
   reg [3:0] st_q;
   reg [3:0] bit_q;
   reg [7:0] sh_q;
   reg [7:0] ptr_q;
   reg       first_q;
   reg       ack_q;
   reg       scl_q;
   reg       sda_q;
   wire scl_rise = scl_in & ~scl_q;
   wire scl_fall = ~scl_in & scl_q;
   wire start_c  = scl_in & scl_q & sda_q & ~sda_in;
   wire stop_c   = scl_in & scl_q & ~sda_q & sda_in;
   assign rd_addr = ptr_q;
   // Bus engine; sda driven only in ack slot or read data
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st_q <= S_IDLE; bit_q <= 4'h0; sh_q <= 8'h00; ptr_q <= 8'h00;
         first_q <= 1'b0; ack_q <= 1'b0; scl_q <= 1'b1; sda_q <= 1'b1;
         sda_oe_n_q <= 1'b1; wr_stb_q <= 1'b0; wr_addr_q <= 8'h00; wr_data_q <= 8'h00;
      end else if (clk_en) begin
         scl_q <= scl_in;
         sda_q <= sda_in;
         wr_stb_q <= 1'b0;
         if (start_c) begin
            st_q <= S_ADDR; bit_q <= `RCL_BIT_PRE; sda_oe_n_q <= 1'b1; ack_q <= 1'b0; // Wraps to 0 at SCL fall
         end else if (stop_c) begin
            st_q <= S_IDLE; sda_oe_n_q <= 1'b1;
         end else if (st_q != S_IDLE) begin
            if (scl_rise && bit_q <= `RCL_BIT_LAST) begin
               // Read bytes shift out on SCL fall only
               if (st_q != S_RD)
                  sh_q <= {sh_q[6:0], sda_in};
               // Read pointer advances at the fifth clock of a sent byte
               if (st_q == S_RD && bit_q == `RCL_BIT_FIFTH && !ack_q)
                  ptr_q <= ptr_q + 8'h01;
            end
            if (scl_rise && bit_q == `RCL_BIT_ACK && st_q == S_RD)
               ack_q <= sda_in;            // High = host NACK
            if (scl_fall) begin
               case (st_q)
                  S_ADDR: begin
                     if (bit_q == `RCL_BIT_LAST) begin
                        if (sh_q[7:1] == dev_addr) begin
                           sda_oe_n_q <= 1'b0;   // R13
                           bit_q <= `RCL_BIT_ACK;
                        end else begin
                           st_q <= S_IDLE;       // R18
                        end
                     end else if (bit_q == `RCL_BIT_ACK) begin
                        bit_q <= 4'h0;
                        first_q <= 1'b1;
                        if (sh_q[0]) begin
                           st_q <= S_RD;
                           sda_oe_n_q <= rd_data[7];
                           sh_q <= {rd_data[6:0], 1'b1};
                        end else begin
                           st_q <= S_WR;
                           sda_oe_n_q <= 1'b1;
                        end
                     end else begin
                        bit_q <= bit_q + 4'h1;
                     end
                  end
                  S_WR: begin
                     if (bit_q == `RCL_BIT_LAST) begin
                        sda_oe_n_q <= 1'b0;      // R13
                        bit_q <= `RCL_BIT_ACK;
                        if (first_q) begin
                           ptr_q <= sh_q;        // R14
                        end else begin
                           wr_stb_q <= 1'b1;     // R15
                           wr_addr_q <= ptr_q;
                           wr_data_q <= sh_q;
                           ptr_q <= ptr_q + 8'h01; // R15
                        end
                        first_q <= 1'b0;
                     end else if (bit_q == `RCL_BIT_ACK) begin
                        sda_oe_n_q <= 1'b1;
                        bit_q <= 4'h0;
                     end else begin
                        bit_q <= bit_q + 4'h1;
                     end
                  end
                  S_RD: begin
                     if (bit_q == `RCL_BIT_LAST) begin
                        sda_oe_n_q <= 1'b1;      // Release for host ack
                        bit_q <= `RCL_BIT_ACK;
                     end else if (bit_q == `RCL_BIT_ACK) begin
                        bit_q <= 4'h0;
                        if (ack_q) begin
                           st_q <= S_IDLE;
                        end else begin
                           sda_oe_n_q <= rd_data[7]; // R17
                           sh_q <= {rd_data[6:0], 1'b1};
                        end
                     end else begin
                        bit_q <= bit_q + 4'h1;
                        sda_oe_n_q <= sh_q[7];
                        sh_q <= {sh_q[6:0], 1'b1};
                     end
                  end
                  default: st_q <= S_IDLE;
               endcase
            end
         end
      end
   end
endmodule

// ===== hdl/rcl_control.v
// Regulator control logic: power sequencer, strap decode and bus target
// Functional notes
// R1: Power loss or input lockout sends any state to no power; power returns to bias ramp.
// R2: Bias ramp powers bias blocks, then waits for the auxiliary buck to come up.
// R3: Frequency resistor check waits for validation, then enters bias ready.
// R4: Bias ready shows bias good and waits for an enable rising edge.
// R5: Main ramp keeps bias good and goes to main on while output good is high.
// R6: Main on shows both goods; a setpoint register write enters servo.
// R7: Servo keeps bias good, drops output good, returns via main ramp on completion.
// R8: Bias faults from normal states enter bias reset, back to bias ramp after delay.
// R9: With enable high, latch-off faults enter main shutdown, then bias ready.
// R10: With enable high, hiccup faults enter main error; restart after hiccup timeout.
// R11: Strap selects one of six addresses from 0001000 to 0001101.
// R12: Strap also selects stand-alone, rising or falling slave, or master clock role.
// R13: A write is start, address, register, data, stop; each byte acknowledged.
// R14: Register pointer loads the register address at the second byte acknowledge.
// R15: Each written byte stores at the pointer, then pointer increments.
// R16: Host sends a zero direction bit and ends writes with a stop.
// R17: Status bits read; setting bits read back the last written value.
// R18: Transactions for another address are neither acknowledged nor acted on.
`timescale 1ns/100ps
`include "rcl_regs.vh"
module rcl_control #(
   parameter NREG       = 16,
   parameter RESET_CYC  = `RCL_RESET_CYC,
   parameter HICCUP_CYC = `RCL_HICCUP_CYC
) (
   // Clock and reset
   input  wire         clk_sys,
   input  wire         rst,
   input  wire         clk_en,
   // Supply and analog status
   input  wire         power_present,
   input  wire         input_low_lockout,
   input  wire         input_high_lockout,
   input  wire         aux_buck_up,
   input  wire         rate_set_resistor_ok,
   input  wire         rate_set_resistor_bad,
   input  wire         bias_fault,
   input  wire         enable_in,
   input  wire         internal_on_request,
   input  wire         output_good_in,
   input  wire         servo_done,
   input  wire         shutdown_done,
   input  wire         latch_fault,
   input  wire         hiccup_fault,
   input  wire [2:0]   bus_id_resistor,
   // Serial bus pins
   input  wire         scl_in,
   input  wire         sda_in,
   output wire         sda_oe_n,
   // Sequencer and strap outputs
   output reg          bias_en_q,
   output reg          main_en_q,
   output reg          bias_good_q,
   output reg          output_good_q,
   output reg  [1:0]   clock_role_q,
   output reg          sync_rise_q,
   output reg  [9:0]   seq_state_q
);
   // ==========================================
   // Strap decode
   reg  [6:0]  dev_addr_q;
   reg  [26:0] tmr_q;
   reg         en_q;
   reg  [7:0]  regs_q [0:NREG-1];
   wire        wr_stb;
   wire [7:0]  wr_addr;
   wire [7:0]  wr_data;
   wire [7:0]  rd_addr;
   wire        en_rise  = enable_in & ~en_q;
   wire        pwr_bad  = ~power_present | input_low_lockout | input_high_lockout;
   wire        set_chg  = wr_stb && (wr_addr == `RCL_REG_VSET || wr_addr == `RCL_REG_ISET);
   wire [7:0]  status_b = {output_good_q, bias_good_q, seq_state_q[5:0]};
   wire [7:0]  rd_data  = (rd_addr == 8'h00 + NREG) ? status_b :
                          (rd_addr < NREG) ? regs_q[rd_addr[3:0]] : 8'h00;
   // Address and clock role from the strap, held each cycle
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         dev_addr_q <= `RCL_ADDR_BASE; clock_role_q <= `RCL_ROLE_ALONE; sync_rise_q <= 1'b0;
      end else if (clk_en) begin
         dev_addr_q <= `RCL_ADDR_BASE + {4'h0, bus_id_resistor}; // R11
         case (bus_id_resistor)                                   // R12
            `RCL_STRAP_GND:  begin clock_role_q <= `RCL_ROLE_ALONE;  sync_rise_q <= 1'b0; end
            `RCL_STRAP_20K,
            `RCL_STRAP_40K:  begin clock_role_q <= `RCL_ROLE_SLAVE;  sync_rise_q <= 1'b1; end
            `RCL_STRAP_30K,
            `RCL_STRAP_50K:  begin clock_role_q <= `RCL_ROLE_SLAVE;  sync_rise_q <= 1'b0; end
            default:         begin clock_role_q <= `RCL_ROLE_MASTER; sync_rise_q <= 1'b0; end
         endcase
      end
   end
   // ==========================================
   // Setting registers, read back as written
   genvar g;
   generate
      for (g = 0; g < NREG; g = g + 1) begin : g_reg
         always @(posedge clk_sys or posedge rst) begin
            if (rst)
               regs_q[g] <= 8'h00;
            else if (clk_en && wr_stb && wr_addr == g)
               regs_q[g] <= wr_data; // R17
         end
      end
   endgenerate
   // ==========================================
   // Sequencer
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         seq_state_q <= `RCL_ST_NOPWR; tmr_q <= 27'h0; en_q <= 1'b0;
         bias_en_q <= 1'b0; main_en_q <= 1'b0; bias_good_q <= 1'b0; output_good_q <= 1'b0;
      end else if (clk_en) begin
         en_q <= enable_in;
         tmr_q <= tmr_q + 27'h1;
         if (pwr_bad) begin
            seq_state_q <= `RCL_ST_NOPWR;                      // R1
         end else if (bias_fault && seq_state_q != `RCL_ST_NOPWR && seq_state_q != `RCL_ST_BRST) begin
            seq_state_q <= `RCL_ST_BRST; tmr_q <= 27'h0;       // R8
         end else if (enable_in && latch_fault && (seq_state_q & (`RCL_ST_MRAMP | `RCL_ST_MON | `RCL_ST_SERVO | `RCL_ST_MERR)) != 10'h000) begin
            seq_state_q <= `RCL_ST_MSHUT;                      // R9
         end else if (enable_in && hiccup_fault && (seq_state_q & (`RCL_ST_MRAMP | `RCL_ST_MON | `RCL_ST_SERVO)) != 10'h000) begin
            seq_state_q <= `RCL_ST_MERR; tmr_q <= 27'h0;       // R10
         end else begin
            case (seq_state_q)
               `RCL_ST_NOPWR: seq_state_q <= `RCL_ST_BRAMP;     // R1
               `RCL_ST_BRAMP: if (aux_buck_up) seq_state_q <= `RCL_ST_RCHK;  // R2
               `RCL_ST_RCHK: begin
                  if (rate_set_resistor_bad) begin
                     seq_state_q <= `RCL_ST_BRST; tmr_q <= 27'h0;             // R8
                  end else if (rate_set_resistor_ok)
                     seq_state_q <= `RCL_ST_BRDY;                             // R3
               end
               `RCL_ST_BRDY:  if (en_rise) seq_state_q <= `RCL_ST_MRAMP;      // R4
               `RCL_ST_MRAMP: if (output_good_in) seq_state_q <= `RCL_ST_MON; // R5
               `RCL_ST_MON:   if (set_chg) seq_state_q <= `RCL_ST_SERVO;      // R6
               `RCL_ST_SERVO: if (servo_done) seq_state_q <= `RCL_ST_MRAMP;   // R7
               `RCL_ST_BRST:  if (tmr_q >= RESET_CYC - 1) seq_state_q <= `RCL_ST_BRAMP; // R8
               `RCL_ST_MSHUT: if (shutdown_done) seq_state_q <= `RCL_ST_BRDY; // R9
               `RCL_ST_MERR: begin
                  if (!internal_on_request)
                     seq_state_q <= `RCL_ST_BRDY;                             // R10
                  else if (tmr_q >= HICCUP_CYC - 1)
                     seq_state_q <= `RCL_ST_MRAMP;                            // R10
               end
               default: seq_state_q <= `RCL_ST_NOPWR;
            endcase
            if (seq_state_q == `RCL_ST_MON && !internal_on_request)
               seq_state_q <= `RCL_ST_MSHUT;                                  // R9
         end
         // Outputs follow the current state
         bias_en_q     <= (seq_state_q & (`RCL_ST_NOPWR | `RCL_ST_BRST)) == 10'h000; // R2
         bias_good_q   <= (seq_state_q & (`RCL_ST_BRDY | `RCL_ST_MRAMP | `RCL_ST_MON | `RCL_ST_SERVO)) != 10'h000; // R4
         output_good_q <= seq_state_q == `RCL_ST_MON;                         // R6
         main_en_q     <= (seq_state_q & (`RCL_ST_MRAMP | `RCL_ST_MON | `RCL_ST_SERVO)) != 10'h000; // R7
      end
   end
   // ==========================================
   // Bus target
   rcl_i2c_target #(.NREG(NREG)) u_tgt (
      .clk_sys    (clk_sys),
      .rst        (rst),
      .clk_en     (clk_en),
      .scl_in     (scl_in),
      .sda_in     (sda_in),
      .sda_oe_n_q (sda_oe_n),
      .dev_addr   (dev_addr_q),
      .wr_stb_q   (wr_stb),
      .wr_addr_q  (wr_addr),
      .wr_data_q  (wr_data),
      .rd_addr    (rd_addr),
      .rd_data    (rd_data)
   );
endmodule

// ===== verif/rcl_i2c_host.sv
// Bus host model driving the serial clock and data lines
`timescale 1ns/100ps
module rcl_i2c_host (
   // Clock and bus line
   input  wire clk_sys,
   input  wire sda_line,
   // Driven pins, high means released
   output reg  scl_q,
   output reg  sda_q
);
   // ==========
   // Bit and frame tasks
   initial begin
      scl_q = 1'b1;
      sda_q = 1'b1;
   end
   // One bit: SDA moves mid low phase, line sampled mid high phase
   task bit_io(input logic b, output logic seen);
      scl_q <= 1'b0;
      repeat (4) @(posedge clk_sys);
      sda_q <= b;
      repeat (4) @(posedge clk_sys);
      scl_q <= 1'b1;
      repeat (4) @(posedge clk_sys);
      seen = sda_line;
      repeat (4) @(posedge clk_sys);
   endtask
   // Start, also used as repeated start
   task bus_start;
      logic x;
      bit_io(1'b1, x);
      sda_q <= 1'b0;
      repeat (8) @(posedge clk_sys);
   endtask
   // Stop closes every transfer
   task bus_stop;
      logic x;
      bit_io(1'b0, x);
      sda_q <= 1'b1;
      repeat (8) @(posedge clk_sys);
   endtask
   // Byte out; the ninth clock returns the acknowledge
   task send_byte(input [7:0] b, output logic ack);
      logic x;
      for (int i = 7; i >= 0; i--)
         bit_io(b[i], x);
      bit_io(1'b1, x);
      ack = ~x;
   endtask
   // Byte in with SDA released; no acknowledge on the last
   task recv_byte(input logic last, output [7:0] b);
      logic x;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, x);
         b[i] = x;
      end
      bit_io(last, x);
   endtask
endmodule

// ===== verif/rcl_checker.sv
// Checker: sequencer and strap properties at the control block ports
`timescale 1ns/100ps
`include "rcl_regs.vh"
module rcl_checker #(
   parameter RESET_CYC = `RCL_RESET_CYC
) (
   // Clock and reset
   input  wire       clk_sys,
   input  wire       rst,
   // Watched inputs
   input  wire       power_present,
   input  wire       input_low_lockout,
   input  wire       input_high_lockout,
   input  wire       bias_fault,
   input  wire       enable_in,
   input  wire       latch_fault,
   input  wire       hiccup_fault,
   input  wire [2:0] bus_id_resistor,
   // Watched outputs
   input  wire       bias_en_q,
   input  wire       main_en_q,
   input  wire       bias_good_q,
   input  wire       output_good_q,
   input  wire [1:0] clock_role_q,
   input  wire       sync_rise_q,
   input  wire [9:0] seq_state_q
);
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   // ==========
   // Helpers: supply good, state groups, bias reset dwell
   wire       pwr_ok = power_present & ~input_low_lockout & ~input_high_lockout;
   wire       mains  = |(seq_state_q & 10'h070);
   wire       norms  = |(seq_state_q & 10'h07E);
   wire [2:0] r      = bus_id_resistor;
   reg [31:0] brst_cnt_q;
   // Counts cycles spent in bias reset
   always @(posedge clk_sys or posedge rst) begin
      if (rst)
         brst_cnt_q <= 32'h0;
      else if (seq_state_q == `RCL_ST_BRST)
         brst_cnt_q <= brst_cnt_q + 32'h1;
      else
         brst_cnt_q <= 32'h0;
   end
   // ==========
   // Properties
   power_off_a: assert property (!pwr_ok |-> ##[1:2] seq_state_q == `RCL_ST_NOPWR)
      else $error("no power state missed");
   power_up_a: assert property (seq_state_q == `RCL_ST_NOPWR && pwr_ok |-> ##[1:2] seq_state_q == `RCL_ST_BRAMP)
      else $error("bias ramp missed");
   bias_ready_a: assert property ((seq_state_q == `RCL_ST_BRDY) [*2] |-> bias_good_q)
      else $error("bias good low in bias ready");
   no_edge_a: assert property (seq_state_q == `RCL_ST_BRDY && !enable_in |=> seq_state_q != `RCL_ST_MRAMP)
      else $error("ramp without enable edge");
   ramp_good_a: assert property ((seq_state_q == `RCL_ST_MRAMP) [*2] |-> bias_good_q)
      else $error("bias good low in main ramp");
   main_on_a: assert property ((seq_state_q == `RCL_ST_MON) [*2] |-> bias_good_q && output_good_q)
      else $error("goods low in main on");
   converter_on_a: assert property ((seq_state_q == `RCL_ST_MON) [*2] |-> bias_en_q && main_en_q)
      else $error("enables low in main on");
   servo_goods_a: assert property ((seq_state_q == `RCL_ST_SERVO) [*2] |-> bias_good_q && !output_good_q)
      else $error("goods wrong in servo");
   bias_fault_a: assert property (bias_fault && pwr_ok && norms |-> ##[1:2] seq_state_q == `RCL_ST_BRST)
      else $error("bias reset missed");
   reset_wait_a: assert property (brst_cnt_q <= RESET_CYC + 2)
      else $error("bias reset overstays");
   latch_off_a: assert property (latch_fault && enable_in && pwr_ok && !bias_fault && mains
      |-> ##[1:2] seq_state_q == `RCL_ST_MSHUT)
      else $error("main shutdown missed");
   hiccup_err_a: assert property (hiccup_fault && !latch_fault && enable_in && pwr_ok && !bias_fault && mains
      |-> ##[1:2] seq_state_q == `RCL_ST_MERR)
      else $error("main error missed");
   strap_role_a: assert property ($stable(r) [*4] |-> clock_role_q == (r == 3'h0 ? `RCL_ROLE_ALONE :
      r == 3'h5 ? `RCL_ROLE_MASTER : `RCL_ROLE_SLAVE) && (r == 3'h0 || r == 3'h5 ||
      sync_rise_q == (r == 3'h1 || r == 3'h3)))
      else $error("clock role wrong for strap");
endmodule
bind rcl_control rcl_checker #(.RESET_CYC(RESET_CYC)) u_chk (
   .clk_sys(clk_sys), .rst(rst), .power_present(power_present), .input_low_lockout(input_low_lockout),
   .input_high_lockout(input_high_lockout), .bias_fault(bias_fault), .enable_in(enable_in),
   .latch_fault(latch_fault), .hiccup_fault(hiccup_fault), .bus_id_resistor(bus_id_resistor),
   .bias_en_q(bias_en_q), .main_en_q(main_en_q),
   .bias_good_q(bias_good_q), .output_good_q(output_good_q), .clock_role_q(clock_role_q),
   .sync_rise_q(sync_rise_q), .seq_state_q(seq_state_q));

// ===== verif/rcl_control_tb.sv
// Testbench: power sequencing, strap addressing and bus register access
`timescale 1ns/100ps
`include "rcl_regs.vh"
module rcl_control_tb;
   localparam RST_N = 20;
   // ==========
   // Stimulus, wires and counters
   reg        clk_sys = 1'b0;
   reg        rst = 1'b1;
   reg        power_present = 1'b0;
   reg        aux_buck_up = 1'b0;
   reg        rate_ok = 1'b0;
   reg        rate_bad = 1'b0;
   reg        bias_fault = 1'b0;
   reg        enable_in = 1'b0;
   reg        output_good_in = 1'b0;
   reg        servo_done = 1'b0;
   reg        shutdown_done = 1'b0;
   reg        latch_fault = 1'b0;
   reg        hiccup_fault = 1'b0;
   reg  [2:0] strap = 3'h0;
   reg  [7:0] wdat [0:2];
   reg  [7:0] rdat [0:2];
   reg  [7:0] n_reg;
   reg  [6:0] adr;
   logic      ok;
   integer    seed;
   integer    failures = 0;
   integer    comparisons = 0;
   wire       scl;
   wire       host_sda;
   wire       sda_oe_n;
   wire       sda_line = host_sda & sda_oe_n;
   wire       bias_good_q;
   wire       output_good_q;
   wire [1:0] clock_role_q;
   wire       sync_rise_q;
   wire [9:0] seq_state_q;
   // Clock
   initial begin
      forever #5 clk_sys = ~clk_sys;
   end
   // Design and bus host
   rcl_control #(.NREG(16), .RESET_CYC(RST_N), .HICCUP_CYC(RST_N)) dut (
      .clk_sys(clk_sys), .rst(rst), .clk_en(1'b1), .power_present(power_present),
      .input_low_lockout(1'b0), .input_high_lockout(1'b0), .aux_buck_up(aux_buck_up),
      .rate_set_resistor_ok(rate_ok), .rate_set_resistor_bad(rate_bad), .bias_fault(bias_fault),
      .enable_in(enable_in), .internal_on_request(1'b1), .output_good_in(output_good_in),
      .servo_done(servo_done), .shutdown_done(shutdown_done), .latch_fault(latch_fault),
      .hiccup_fault(hiccup_fault), .bus_id_resistor(strap), .scl_in(scl), .sda_in(sda_line),
      .sda_oe_n(sda_oe_n), .bias_en_q(), .main_en_q(), .bias_good_q(bias_good_q),
      .output_good_q(output_good_q), .clock_role_q(clock_role_q), .sync_rise_q(sync_rise_q),
      .seq_state_q(seq_state_q));
   rcl_i2c_host host (.clk_sys(clk_sys), .sda_line(sda_line), .scl_q(scl), .sda_q(host_sda));
   // ==========
   // Expectations and tasks
   function [6:0] exp_addr(input [2:0] c);
      exp_addr = `RCL_ADDR_BASE + {4'h0, c};
   endfunction
   function [1:0] exp_role(input [2:0] c);
      exp_role = (c == 3'h0) ? `RCL_ROLE_ALONE : (c == 3'h5) ? `RCL_ROLE_MASTER : `RCL_ROLE_SLAVE;
   endfunction
   task chk(input string what, input [15:0] exp, input [15:0] got);
      comparisons = comparisons + 1;
      if (got !== exp) begin
         failures = failures + 1;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task summarize;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task do_reset;
      rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (3) @(posedge clk_sys);
   endtask
   // Waits for a state; goods holds check flag, output good, bias good
   task wait_state(input [9:0] exp, input [2:0] goods, input integer lim);
      integer c;
      c = 0;
      @(negedge clk_sys);
      while (seq_state_q !== exp && c < lim) begin
         @(negedge clk_sys);
         c = c + 1;
      end
      chk("state", {6'h0, exp}, {6'h0, seq_state_q});
      @(negedge clk_sys);
      if (goods[2])
         chk("goods", {14'h0, goods[1:0]}, {14'h0, output_good_q, bias_good_q});
      @(posedge clk_sys);
   endtask
   // Write: address with write bit, pointer, then n data bytes
   task bus_write(input [6:0] a, input [7:0] r, input integer n, output logic all);
      logic k;
      host.bus_start;
      host.send_byte({a, 1'b0}, all);
      host.send_byte(r, k);
      all = all & k;
      for (int i = 0; i < n; i++) begin
         host.send_byte(wdat[i], k);
         all = all & k;
      end
      host.bus_stop;
   endtask
   // Pointer set, repeated start, n bytes read
   task bus_read(input [6:0] a, input [7:0] r, input integer n);
      logic k;
      host.bus_start;
      host.send_byte({a, 1'b0}, k);
      host.send_byte(r, k);
      host.bus_start;
      host.send_byte({a, 1'b1}, k);
      for (int i = 0; i < n; i++)
         host.recv_byte(i == n - 1, rdat[i]);
      host.bus_stop;
   endtask
   // ==========
   // Main sequence
   initial begin
      seed = $urandom(32'hF5134AFC);
      do_reset;
      power_present <= 1'b1;
      wait_state(`RCL_ST_BRAMP, 3'h0, 8);
      aux_buck_up <= 1'b1;
      wait_state(`RCL_ST_RCHK, 3'h0, 8);
      rate_ok <= 1'b1;
      wait_state(`RCL_ST_BRDY, 3'h5, 8);
      for (int s = 0; s < 6; s++) begin
         strap <= 3'(s);
         do_reset;
         bus_write(exp_addr(strap), 8'h05, 0, ok);
         chk("ack", 16'h1, {15'h0, ok});
         chk("role", {14'h0, exp_role(strap)}, {14'h0, clock_role_q});
         if (exp_role(strap) == `RCL_ROLE_SLAVE)
            chk("rise", {15'h0, strap == 3'h1 || strap == 3'h3}, {15'h0, sync_rise_q});
         bus_write(exp_addr(strap == 3'h5 ? 3'h0 : strap + 3'h1), 8'h05, 0, ok);
         chk("nack", 16'h0, {15'h0, ok});
      end
      adr = exp_addr(strap);
      n_reg = 8'h02 + 8'($urandom % 12);
      for (int i = 0; i < 3; i++)
         wdat[i] = 8'($urandom);
      bus_write(adr, n_reg, 3, ok);
      chk("wr ack", 16'h1, {15'h0, ok});
      bus_read(adr, n_reg, 3);
      for (int i = 0; i < 3; i++)
         chk("data", {8'h0, wdat[i]}, {8'h0, rdat[i]});
      wdat[0] = ~wdat[0];
      bus_write(7'h50, n_reg, 1, ok);
      bus_read(adr, n_reg, 1);
      chk("ignored", {8'h0, ~wdat[0]}, {8'h0, rdat[0]});
      bus_read(adr, 8'h10, 1);
      chk("status", 16'h0048, {8'h0, rdat[0]});
      enable_in <= 1'b1;
      wait_state(`RCL_ST_MRAMP, 3'h5, 8);
      output_good_in <= 1'b1;
      wait_state(`RCL_ST_MON, 3'h7, 8);
      wdat[0] = 8'($urandom);
      bus_write(adr, `RCL_REG_VSET, 1, ok);
      wait_state(`RCL_ST_SERVO, 3'h5, 8);
      servo_done <= 1'b1;
      wait_state(`RCL_ST_MON, 3'h7, 20);
      servo_done <= 1'b0;
      latch_fault <= 1'b1;
      wait_state(`RCL_ST_MSHUT, 3'h0, 8);
      latch_fault <= 1'b0;
      shutdown_done <= 1'b1;
      wait_state(`RCL_ST_BRDY, 3'h5, 8);
      shutdown_done <= 1'b0;
      enable_in <= 1'b0;
      @(posedge clk_sys);
      enable_in <= 1'b1;
      wait_state(`RCL_ST_MON, 3'h7, 20);
      hiccup_fault <= 1'b1;
      wait_state(`RCL_ST_MERR, 3'h0, 8);
      hiccup_fault <= 1'b0;
      wait_state(`RCL_ST_MRAMP, 3'h0, 2 * RST_N + 8);
      bias_fault <= 1'b1;
      wait_state(`RCL_ST_BRST, 3'h0, 8);
      bias_fault <= 1'b0;
      wait_state(`RCL_ST_BRAMP, 3'h0, 2 * RST_N + 8);
      power_present <= 1'b0;
      wait_state(`RCL_ST_NOPWR, 3'h4, 8);
      rate_ok <= 1'b0;
      rate_bad <= 1'b1;
      power_present <= 1'b1;
      wait_state(`RCL_ST_BRST, 3'h4, 8);
      summarize;
   end
   // Watchdog against a hang
   initial begin
      repeat (40000) @(posedge clk_sys);
      failures = failures + 1;
      summarize;
   end
endmodule
